// file: rtl/dacf_ctrl.sv
// Behaviour
// - Enable bit powers converter B; zero holds it in shutdown.
// - Track mode zero tracks continuously; one tracks only before conversion.
// - Done flag set on completion, cleared only by software writing zero.
// - Busy reads one during conversion; its falling edge sets done flag only while converter B is enabled.
// - Busy write of one starts conversion if busy-write source selected.
// - Track mode zero: 000 busy write, 100 pin rising edge start.
// - Track mode one: 010 timer3 tracks, 100 pin converts, xx1 busy tracks.
// - Each converter has its own bias generator enable bit.
// - Each converter has a reference buffer enable bit.
// - Single-ended result is 16-bit unsigned binary.
// - Differential result is 16-bit signed two's complement.
// - Differential combined result goes into converter A result registers.
// - Converter B single-ended result always lands in B result registers.
`include "dacf_map.svh"
module dacf_ctrl #(
    parameter int TRACK_CYC = `DACF_TRACK_CYC
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire dacf_pkg::dacf_byte_t reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output dacf_pkg::dacf_byte_t reg_rdata,
    input wire logic timer3_ovf,
    input wire logic timer2_ovf,
    input wire logic external_convert_start_b,
    input wire logic conv_a_done,
    input wire dacf_pkg::dacf_word_t conv_a_data,
    input wire logic conv_b_done,
    input wire dacf_pkg::dacf_word_t conv_b_data,
    output logic conv_b_power,
    output logic conv_b_track,
    output logic conv_b_start,
    output logic bias_gen_enable_a,
    output logic bias_gen_enable_b,
    output logic ref_buffer_enable_a,
    output logic ref_buffer_enable_b,
    output logic irq
);
    import dacf_pkg::*;

    localparam int TCW = $clog2(TRACK_CYC + 1);

    logic conv_b_enable;
    logic conv_b_track_mode;
    logic conv_b_done_flag;
    logic [2:0] conv_b_start_source;
    dacf_byte_t ref_a_r;
    dacf_byte_t ref_b_r;
    logic diff_mode_r;
    logic [1:0] istat_r;
    logic [1:0] imask_r;
    dacf_word_t result_a_r;
    dacf_word_t result_b_r;
    dacf_state_e state_r;
    logic [TCW-1:0] track_cnt_r;
    logic pin_s1_r;
    logic pin_s2_r;
    logic pin_s3_r;
    logic conv_b_busy_bit;
    logic busy_d_r;
    logic start_pulse_r;
    dacf_byte_t rdata_r;

    logic wr_ctrl;
    logic busy_write;
    logic pin_rise;
    logic trig;
    logic trig_tracks;
    logic busy_fall;
    logic [16:0] diff_full;

    assign wr_ctrl = reg_wr && (reg_addr == `DACF_OFF_CTRL);
    assign busy_write = wr_ctrl && reg_wdata[`DACF_CTL_BUSY];
    assign pin_rise = pin_s2_r && !pin_s3_r;

    // Pin passes two flops before edge detection
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pin_s1_r <= 1'b0;
            pin_s2_r <= 1'b0;
            pin_s3_r <= 1'b0;
        end else begin
            pin_s1_r <= external_convert_start_b;
            pin_s2_r <= pin_s1_r;
            pin_s3_r <= pin_s2_r;
        end
    end

    // Start source decode
    always_comb begin
        trig = 1'b0;
        trig_tracks = 1'b0;
        if (conv_b_start_source[0]) begin
            trig = busy_write;
            trig_tracks = conv_b_track_mode;
        end else begin
            unique case (conv_b_start_source)
                3'h0: begin
                    trig = busy_write;
                    trig_tracks = conv_b_track_mode;
                end
                `DACF_SRC_T3: begin
                    trig = timer3_ovf;
                    trig_tracks = conv_b_track_mode;
                end
                `DACF_SRC_PIN: begin
                    trig = pin_rise;
                end
                `DACF_SRC_T2: begin
                    trig = timer2_ovf;
                    trig_tracks = conv_b_track_mode;
                end
                default: begin
                    trig = 1'b0;
                end
            endcase
        end
    end

    // Conversion sequencer
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_r <= DACF_IDLE;
            track_cnt_r <= '0;
            start_pulse_r <= 1'b0;
        end else begin
            start_pulse_r <= 1'b0;
            if (!conv_b_enable) begin
                state_r <= DACF_IDLE;
                track_cnt_r <= '0;
            end else begin
                unique case (state_r)
                    DACF_IDLE: begin
                        if (trig && trig_tracks) begin
                            state_r <= DACF_TRACK;
                            track_cnt_r <= TCW'(TRACK_CYC - 1);
                        end else if (trig) begin
                            state_r <= DACF_CONV;
                            start_pulse_r <= 1'b1;
                        end
                    end
                    DACF_TRACK: begin
                        if (track_cnt_r == '0) begin
                            state_r <= DACF_CONV;
                            start_pulse_r <= 1'b1;
                        end else begin
                            track_cnt_r <= track_cnt_r - 1'b1;
                        end
                    end
                    DACF_CONV: begin
                        if (conv_b_done) begin
                            state_r <= DACF_IDLE;
                        end
                    end
                    default: begin
                        state_r <= DACF_IDLE;
                    end
                endcase
            end
        end
    end

    assign conv_b_busy_bit = (state_r != DACF_IDLE);

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            busy_d_r <= 1'b0;
        end else begin
            busy_d_r <= conv_b_busy_bit;
        end
    end

    // Completion only counts while enabled
    assign busy_fall = busy_d_r && !conv_b_busy_bit && conv_b_enable;

    // Control register fields
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            conv_b_enable <= 1'(`DACF_RST_CTRL >> `DACF_CTL_EN);
            conv_b_track_mode <= 1'b0;
            conv_b_start_source <= 3'h0;
        end else if (wr_ctrl) begin
            conv_b_enable <= reg_wdata[`DACF_CTL_EN];
            conv_b_track_mode <= reg_wdata[`DACF_CTL_TM];
            conv_b_start_source <=
                reg_wdata[`DACF_CTL_SRC_HI:`DACF_CTL_SRC_LO];
        end
    end

    // Done flag: set wins over software clear
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            conv_b_done_flag <= 1'b0;
        end else if (busy_fall) begin
            conv_b_done_flag <= 1'b1;
        end else if (wr_ctrl && !reg_wdata[`DACF_CTL_DONE]) begin
            conv_b_done_flag <= 1'b0;
        end
    end

    // Reference controls and mode config
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ref_a_r <= `DACF_RST_REF;
            ref_b_r <= `DACF_RST_REF;
            diff_mode_r <= 1'b0;
        end else if (reg_wr) begin
            if (reg_addr == `DACF_OFF_REFA) begin
                ref_a_r <= reg_wdata & 8'h03;
            end
            if (reg_addr == `DACF_OFF_REFB) begin
                ref_b_r <= reg_wdata & 8'h03;
            end
            if (reg_addr == `DACF_OFF_CFG) begin
                diff_mode_r <= reg_wdata[`DACF_CFG_DIFF];
            end
        end
    end

    // Differential word: half the difference of the two codes
    assign diff_full = {1'b0, conv_a_data} - {1'b0, conv_b_data};

    // Result capture
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            result_a_r <= 16'h0000;
            result_b_r <= 16'h0000;
        end else begin
            if (conv_b_done && state_r == DACF_CONV && conv_b_enable) begin
                result_b_r <= conv_b_data;
                if (diff_mode_r) begin
                    result_a_r <= diff_full[16:1];
                end
            end
            if (conv_a_done && !diff_mode_r) begin
                result_a_r <= conv_a_data;
            end
        end
    end

    // Interrupt status, write one to clear, set wins
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            istat_r <= 2'h0;
            imask_r <= 2'h0;
        end else begin
            if (reg_wr && reg_addr == `DACF_OFF_IMASK) begin
                imask_r <= reg_wdata[1:0];
            end
            if (busy_fall) begin
                istat_r[`DACF_IRQ_DONE] <= 1'b1;
            end else if (reg_wr && reg_addr == `DACF_OFF_ISTAT &&
                         reg_wdata[`DACF_IRQ_DONE]) begin
                istat_r[`DACF_IRQ_DONE] <= 1'b0;
            end
            if (trig && conv_b_enable && state_r != DACF_IDLE) begin
                istat_r[`DACF_IRQ_OVR] <= 1'b1;
            end else if (reg_wr && reg_addr == `DACF_OFF_ISTAT &&
                         reg_wdata[`DACF_IRQ_OVR]) begin
                istat_r[`DACF_IRQ_OVR] <= 1'b0;
            end
        end
    end

    // Read data one cycle after the strobe
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rdata_r <= 8'h00;
        end else if (reg_rd) begin
            unique case (reg_addr)
                `DACF_OFF_CTRL: rdata_r <= {conv_b_enable, conv_b_track_mode,
                    conv_b_done_flag, conv_b_busy_bit,
                    conv_b_start_source, 1'b0};
                `DACF_OFF_REFA: rdata_r <= ref_a_r;
                `DACF_OFF_REFB: rdata_r <= ref_b_r;
                `DACF_OFF_RAH: rdata_r <= result_a_r[15:8];
                `DACF_OFF_RAL: rdata_r <= result_a_r[7:0];
                `DACF_OFF_RBH: rdata_r <= result_b_r[15:8];
                `DACF_OFF_RBL: rdata_r <= result_b_r[7:0];
                `DACF_OFF_CFG: rdata_r <= {7'h00, diff_mode_r};
                `DACF_OFF_ISTAT: rdata_r <= {6'h00, istat_r};
                `DACF_OFF_IMASK: rdata_r <= {6'h00, imask_r};
                default: rdata_r <= 8'h00;
            endcase
        end else begin
            rdata_r <= 8'h00;
        end
    end

    assign reg_rdata = rdata_r;
    assign conv_b_power = conv_b_enable;
    assign conv_b_track = conv_b_enable &&
        (!conv_b_track_mode || state_r == DACF_TRACK);
    assign conv_b_start = start_pulse_r;
    assign bias_gen_enable_a = ref_a_r[`DACF_REF_BIAS];
    assign bias_gen_enable_b = ref_b_r[`DACF_REF_BIAS];
    assign ref_buffer_enable_a = ref_a_r[`DACF_REF_BUF];
    assign ref_buffer_enable_b = ref_b_r[`DACF_REF_BUF];
    assign irq = |(istat_r & imask_r);
endmodule

// file: rtl/dacf_map.svh
`ifndef DACF_MAP_SVH
`define DACF_MAP_SVH
// Register offsets
`define DACF_OFF_CTRL 8'h00
`define DACF_OFF_REFA 8'h01
`define DACF_OFF_REFB 8'h02
`define DACF_OFF_RAH 8'h03
`define DACF_OFF_RAL 8'h04
`define DACF_OFF_RBH 8'h05
`define DACF_OFF_RBL 8'h06
`define DACF_OFF_CFG 8'h07
`define DACF_OFF_ISTAT 8'h08
`define DACF_OFF_IMASK 8'h09
// Converter B control fields
`define DACF_CTL_EN 7
`define DACF_CTL_TM 6
`define DACF_CTL_DONE 5
`define DACF_CTL_BUSY 4
`define DACF_CTL_SRC_HI 3
`define DACF_CTL_SRC_LO 1
// Reference control fields
`define DACF_REF_BIAS 1
`define DACF_REF_BUF 0
// Config and interrupt fields
`define DACF_CFG_DIFF 0
`define DACF_IRQ_DONE 0
`define DACF_IRQ_OVR 1
// Reset values
`define DACF_RST_CTRL 8'h00
`define DACF_RST_REF 8'h00
// Start source codes
`define DACF_SRC_T3 3'h2
`define DACF_SRC_PIN 3'h4
`define DACF_SRC_T2 3'h6
// Timing
`define DACF_CLK_MHZ 40
`define DACF_TRACK_NS 300
`define DACF_TRACK_CYC ((`DACF_TRACK_NS * `DACF_CLK_MHZ + 999) / 1000)
`endif

// file: rtl/dacf_pkg.sv
package dacf_pkg;
    typedef logic [7:0] dacf_byte_t;
    typedef logic [15:0] dacf_word_t;
    typedef enum logic [1:0] {
        DACF_IDLE = 2'b00,
        DACF_TRACK = 2'b01,
        DACF_CONV = 2'b10
    } dacf_state_e;
endpackage

// file: sim/dacf_ctrl_asserts.sv
`include "dacf_map.svh"
module dacf_ctrl_asserts (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire dacf_pkg::dacf_byte_t reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire dacf_pkg::dacf_byte_t reg_rdata,
    input wire logic conv_b_power,
    input wire logic conv_b_track,
    input wire logic conv_b_start,
    input wire logic bias_gen_enable_a,
    input wire logic ref_buffer_enable_b,
    input wire logic irq
);
    import dacf_pkg::*;
    logic tm_r;
    wire ctl_wr = reg_wr && reg_addr == `DACF_OFF_CTRL;
    wire refa_wr = reg_wr && reg_addr == `DACF_OFF_REFA;

    // Shadow of the track-mode bit
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst)
            tm_r <= 1'b0;
        else if (ctl_wr)
            tm_r <= reg_wdata[6];
    end

    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);

    a_enable_write: assert property (ctl_wr |=>
        conv_b_power == $past(reg_wdata[7])) else $error("enable bad");
    a_track_cont: assert property (conv_b_power && !tm_r |->
        conv_b_track) else $error("track not continuous");
    a_track_off: assert property (!conv_b_power |->
        !conv_b_track) else $error("track while off");
    a_start_single: assert property (conv_b_start |=>
        !conv_b_start) else $error("start too long");
    a_start_off: assert property (!conv_b_power &&
        !$past(conv_b_power) |-> !conv_b_start) else $error("start off");
    a_bias_write: assert property (refa_wr |=>
        bias_gen_enable_a == $past(reg_wdata[1])) else $error("bias bad");
    a_bias_hold: assert property (!refa_wr |=>
        $stable(bias_gen_enable_a)) else $error("bias moved");
    a_buffer_write: assert property (reg_wr &&
        reg_addr == `DACF_OFF_REFB |=> ref_buffer_enable_b ==
        $past(reg_wdata[0])) else $error("buffer bad");
    a_read_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("read data not idle");
    a_mask_off: assert property (reg_wr && reg_addr == `DACF_OFF_IMASK &&
        reg_wdata == 8'h00 |=> !irq) else $error("irq not masked");
endmodule

bind dacf_ctrl dacf_ctrl_asserts u_asserts (.ref_clk(ref_clk), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .conv_b_power(conv_b_power),
    .conv_b_track(conv_b_track), .conv_b_start(conv_b_start),
    .bias_gen_enable_a(bias_gen_enable_a),
    .ref_buffer_enable_b(ref_buffer_enable_b), .irq(irq));

// file: sim/test_dual_adc_control_and_result_format.sv
`include "dacf_map.svh"
module test_dual_adc_control_and_result_format;
    timeunit 1ns;
    timeprecision 1ps;
    import dacf_pkg::*;
    localparam int TRK = 2;
    logic ref_clk, rst, reg_wr, reg_rd, timer3_ovf, timer2_ovf, diff;
    logic external_convert_start_b, conv_a_done, conv_b_done, irq;
    logic conv_b_power, conv_b_track, conv_b_start;
    logic bias_gen_enable_a, bias_gen_enable_b;
    logic ref_buffer_enable_a, ref_buffer_enable_b;
    logic [7:0] reg_addr;
    dacf_byte_t reg_wdata, reg_rdata;
    dacf_word_t conv_a_data, conv_b_data;
    dacf_word_t pa[4] = '{16'hffff, 16'h8000, 16'h0002, 16'h1234};
    dacf_word_t pb[4] = '{16'h0000, 16'h0000, 16'h0000, 16'h1234};
    dacf_word_t sv[3] = '{16'h0000, 16'h8000, 16'hffff};
    int n_fail, n_checks;
    logic [31:0] seed = 32'h5ff5;

    dacf_ctrl #(.TRACK_CYC(TRK)) dut (
        .ref_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .timer3_ovf, .timer2_ovf, .external_convert_start_b, .conv_a_done,
        .conv_a_data, .conv_b_done, .conv_b_data, .conv_b_power,
        .conv_b_track, .conv_b_start, .bias_gen_enable_a, .bias_gen_enable_b,
        .ref_buffer_enable_a, .ref_buffer_enable_b, .irq
    );

    function automatic logic [15:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[15:0];
    endfunction

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rc(input logic [7:0] a, input logic [7:0] e);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(negedge ref_clk);
        chk(16'(reg_rdata), 16'(e));
    endtask

    // how: 0 busy write, 1 pin, 2 timer 3, 3 timer 2
    // lat: 1 direct, 2 tracked, 0 pin synchroniser delay
    task automatic conv(input logic [7:0] ctl, input int how, input int lat,
        input dacf_word_t a, input dacf_word_t b);
        int i;
        int d;
        wr(`DACF_OFF_CTRL, ctl);
        if (how == 0)
            wr(`DACF_OFF_CTRL, ctl | 8'h10);
        else if (how == 1)
            external_convert_start_b <= 1'b1;
        else begin
            timer3_ovf <= (how == 2);
            timer2_ovf <= (how == 3);
            @(posedge ref_clk);
            timer3_ovf <= 1'b0;
            timer2_ovf <= 1'b0;
        end
        i = 0;
        @(negedge ref_clk);
        while (conv_b_start !== 1'b1 && i < 60) begin
            i++;
            @(negedge ref_clk);
        end
        chk(16'(conv_b_start), 16'h0001);
        chk(16'(i == (lat == 1 ? 0 : lat == 2 ? TRK : 3)), 16'h0001);
        rc(`DACF_OFF_CTRL, ctl | 8'h10);
        // Second busy write while converting counts as overrun
        if (how == 0)
            wr(`DACF_OFF_CTRL, ctl | 8'h10);
        @(posedge ref_clk);
        conv_a_data <= a;
        conv_b_data <= b;
        conv_b_done <= 1'b1;
        @(posedge ref_clk);
        conv_b_done <= 1'b0;
        external_convert_start_b <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rc(`DACF_OFF_CTRL, ctl | 8'h20);
        chk(16'(irq), 16'h0001);
        rc(`DACF_OFF_ISTAT, {6'h00, how == 0, 1'b1});
        rc(`DACF_OFF_RBH, b[15:8]);
        rc(`DACF_OFF_RBL, b[7:0]);
        d = (int'(a) - int'(b)) >>> 1;
        if (diff) begin
            rc(`DACF_OFF_RAH, d[15:8]);
            rc(`DACF_OFF_RAL, d[7:0]);
        end
        wr(`DACF_OFF_IMASK, 8'h00);
        @(negedge ref_clk);
        chk(16'(irq), 16'h0000);
        wr(`DACF_OFF_IMASK, 8'h01);
        wr(`DACF_OFF_ISTAT, 8'h03);
        @(negedge ref_clk);
        chk(16'(irq), 16'h0000);
    endtask

    task automatic wrap_up();
        $display("checks=%0d mismatches=%0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    initial begin
        repeat (20000) @(posedge ref_clk);
        n_fail++;
        wrap_up();
    end

    initial begin
        rst = 1'b1;
        {reg_wr, reg_rd, timer3_ovf, timer2_ovf, diff} = '0;
        {external_convert_start_b, conv_a_done, conv_b_done} = '0;
        reg_addr = '0;
        reg_wdata = '0;
        conv_a_data = '0;
        conv_b_data = '0;
        repeat (8) @(posedge ref_clk);
        rst <= 1'b0;
        rc(`DACF_OFF_CTRL, 8'h00);
        rc(`DACF_OFF_REFA, 8'h00);
        rc(`DACF_OFF_REFB, 8'h00);
        rc(8'h0a, 8'h00);
        wr(`DACF_OFF_REFA, 8'hff);
        rc(`DACF_OFF_REFA, 8'h03);
        chk(16'({bias_gen_enable_a, ref_buffer_enable_a}), 16'h3);
        wr(`DACF_OFF_REFB, 8'h01);
        rc(`DACF_OFF_REFB, 8'h01);
        chk(16'({bias_gen_enable_b, ref_buffer_enable_b}), 16'h1);
        wr(`DACF_OFF_REFB, 8'h03);
        wr(`DACF_OFF_CTRL, 8'h10);
        repeat (4) @(negedge ref_clk);
        chk(16'({conv_b_start, conv_b_power}), 16'h0);
        rc(`DACF_OFF_CTRL, 8'h00);
        wr(`DACF_OFF_IMASK, 8'h01);
        conv(8'h80, 0, 1, rnd(), rnd());
        chk(16'(conv_b_track), 16'h0001);
        conv(8'h88, 1, 0, rnd(), rnd());
        conv(8'hc4, 2, 2, rnd(), rnd());
        conv(8'hcc, 3, 2, rnd(), rnd());
        conv(8'hc2, 0, 2, rnd(), rnd());
        conv(8'hc8, 1, 0, rnd(), rnd());
        chk(16'(conv_b_track), 16'h0000);
        diff = 1'b1;
        wr(`DACF_OFF_CFG, 8'h01);
        foreach (pa[k])
            conv(8'h80, 0, 1, pa[k], pb[k]);
        conv(8'h80, 0, 1, rnd(), rnd());
        diff = 1'b0;
        wr(`DACF_OFF_CFG, 8'h00);
        foreach (sv[k]) begin
            @(posedge ref_clk);
            conv_a_data <= sv[k];
            conv_a_done <= 1'b1;
            @(posedge ref_clk);
            conv_a_done <= 1'b0;
            rc(`DACF_OFF_RAH, sv[k][15:8]);
            rc(`DACF_OFF_RAL, sv[k][7:0]);
        end
        wrap_up();
    end
endmodule
